// >>> dbg_port_ir.sv
// Instruction register of the serial debug port with its test access port controller
`timescale 1ns/1ps

// Overview of operation
// - Sixteen-bit instruction register; processor reads it, processor accesses never change it.
// - After initialization the register holds the bypass command.
// - Command bits are shifted in serially from the test data input.
// - Test reset pin or Test-Logic-Reset state reloads the initial contents.
// - Serial loading works in every processor mode, independent of processor state.
// - Bits 15..8 decode extest, sample, reset negate/assert, interrupt, bypass; rest reserved.
// - Bits 7..0 always read as one; writers supply only ones there.
module dbg_port_ir
    import dbg_port_pkg::*;
(
    // Clock and reset
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_n,
    // Test access port pins
    input  wire tap_pins_type  i_tap,
    output logic               o_tdo,
    output logic               o_tdo_oe,
    // Boundary chain serial output, shifted when extest or sample is active
    input  wire logic          i_chain_tdo,
    // Processor read port
    input  wire logic          i_cpu_rd_en,
    output logic [15:0]        o_cpu_rd_data,
    output logic               o_cpu_rd_valid,
    // Decoded command
    output test_mode_type      o_mode,
    output logic               o_debug_reset,
    output logic               o_debug_irq,
    output logic               o_chain_capture,
    output logic               o_chain_shift,
    output logic               o_chain_update
);

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    tap_pins_type  sync1_reg;
    tap_pins_type  sync2_reg;
    logic          tck_d_reg;
    logic          tck_rise;
    logic          tck_fall;
    logic          trst_active;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            sync2_reg <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            tck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= i_tap;
            sync2_reg <= sync1_reg;
            tck_d_reg <= sync2_reg.tck;
        end
    end

    assign tck_rise    = sync2_reg.tck & ~tck_d_reg;
    assign tck_fall    = ~sync2_reg.tck & tck_d_reg;
    assign trst_active = ~sync2_reg.trst_n;

    // ****************************************
    // Controller state machine
    // ****************************************
    tap_state_type state_reg;
    tap_state_type state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TAP_RESET:  state_next = sync2_reg.tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   state_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: state_next = sync2_reg.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: state_next = sync2_reg.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  state_next = sync2_reg.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: state_next = sync2_reg.tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  state_next = sync2_reg.tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: state_next = sync2_reg.tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: state_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: state_next = sync2_reg.tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: state_next = sync2_reg.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  state_next = sync2_reg.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: state_next = sync2_reg.tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  state_next = sync2_reg.tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: state_next = sync2_reg.tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: state_next = sync2_reg.tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // Controller moves on test clock or test reset only; no processor signal enters here
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= TAP_RESET;
        end else if (trst_active) begin
            state_reg <= TAP_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Instruction shift and update
    // ****************************************
    logic [15:0] shift_reg;
    logic [15:0] ir_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_reg <= IR_CAPTURE;
        end else if (tck_rise && state_reg == TAP_CAP_IR) begin
            shift_reg <= IR_CAPTURE;
        end else if (tck_rise && state_reg == TAP_SH_IR) begin
            shift_reg <= {sync2_reg.tdi, shift_reg[15:1]};
        end
    end

    // Active command is held while a new one shifts; low byte forced to ones
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_reg <= IR_RESET_VALUE;
        end else if (trst_active || (tck_rise && state_reg == TAP_RESET)) begin
            ir_reg <= IR_RESET_VALUE;
        end else if (tck_rise && state_reg == TAP_UPD_IR) begin
            ir_reg <= {shift_reg[CMD_MSB:CMD_LSB], RSVD_READ};
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    logic [7:0] cmd;
    logic [7:0] new_cmd;
    logic       upd_ir;

    assign cmd     = ir_reg[CMD_MSB:CMD_LSB];
    assign new_cmd = shift_reg[CMD_MSB:CMD_LSB];
    assign upd_ir  = tck_rise && state_reg == TAP_UPD_IR && !trst_active;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mode <= '{extest: 1'b0, sample: 1'b0, bypass: 1'b1, reserved: 1'b0};
        end else begin
            o_mode.extest   <= (cmd == CMD_EXTEST);
            o_mode.sample   <= (cmd == CMD_SAMPLE);
            o_mode.bypass   <= (cmd == CMD_BYPASS);
            // Reserved codes leave every function idle; bypass path still shifts
            o_mode.reserved <= !(cmd == CMD_EXTEST || cmd == CMD_SAMPLE || cmd == CMD_BYPASS
                                 || cmd[7:4] == CMD_RST_NEGATE || cmd[7:4] == CMD_RST_ASSERT
                                 || cmd[7:5] == CMD_INTERRUPT);
        end
    end

    // Debug reset is a level kept until the negate command, test reset or Test-Logic-Reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_debug_reset <= 1'b0;
        end else if (trst_active || (tck_rise && state_reg == TAP_RESET)) begin
            o_debug_reset <= 1'b0;
        end else if (upd_ir && new_cmd[7:4] == CMD_RST_ASSERT) begin
            o_debug_reset <= 1'b1;
        end else if (upd_ir && new_cmd[7:4] == CMD_RST_NEGATE) begin
            o_debug_reset <= 1'b0;
        end
    end

    // Interrupt request is one pulse per update of the interrupt command
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_debug_irq <= 1'b0;
        end else begin
            o_debug_irq <= upd_ir && new_cmd[7:5] == CMD_INTERRUPT;
        end
    end

    // ****************************************
    // Data register path and serial output
    // ****************************************
    logic bypass_reg;
    logic chain_sel;

    assign chain_sel = o_mode.extest | o_mode.sample;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bypass_reg <= 1'b0;
        end else if (tck_rise && state_reg == TAP_CAP_DR) begin
            bypass_reg <= 1'b0;
        end else if (tck_rise && state_reg == TAP_SH_DR) begin
            bypass_reg <= sync2_reg.tdi;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_chain_capture <= 1'b0;
            o_chain_shift   <= 1'b0;
            o_chain_update  <= 1'b0;
        end else begin
            o_chain_capture <= chain_sel && tck_rise && state_reg == TAP_CAP_DR;
            o_chain_shift   <= chain_sel && tck_rise && state_reg == TAP_SH_DR;
            o_chain_update  <= chain_sel && tck_rise && state_reg == TAP_UPD_DR;
        end
    end

    // Output changes on the falling test clock so the controller samples it stable
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tdo    <= 1'b1;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo_oe <= (state_reg == TAP_SH_IR) || (state_reg == TAP_SH_DR);
            if (state_reg == TAP_SH_IR) begin
                o_tdo <= shift_reg[0];
            end else if (chain_sel) begin
                o_tdo <= i_chain_tdo;
            end else begin
                o_tdo <= bypass_reg;
            end
        end
    end

    // ****************************************
    // Processor read port
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_rd_data  <= IR_RESET_VALUE;
            o_cpu_rd_valid <= 1'b0;
        end else begin
            o_cpu_rd_valid <= i_cpu_rd_en;
            if (i_cpu_rd_en) begin
                o_cpu_rd_data <= {ir_reg[CMD_MSB:CMD_LSB], RSVD_READ};
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_ir_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (!trst_active && !(tck_rise && (state_reg == TAP_UPD_IR || state_reg == TAP_RESET)))
            |=> $stable(ir_reg);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed outside update");

    property p_bypass_after_reset;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> ##2 (ir_reg == IR_RESET_VALUE && o_mode.bypass);
    endproperty
    a_bypass_after_reset: assert property (p_bypass_after_reset) else $error("not bypass after init");

    property p_shift_in;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tck_rise && state_reg == TAP_SH_IR && !trst_active) |=> shift_reg[15] == $past(sync2_reg.tdi);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("test data input not shifted in");

    property p_trst_init;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        trst_active |=> (ir_reg == IR_RESET_VALUE && state_reg == TAP_RESET && !o_debug_reset);
    endproperty
    a_trst_init: assert property (p_trst_init) else $error("test reset did not initialise");

    property p_cpu_independent;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cpu_rd_en && !tck_rise && !trst_active) |=> $stable(ir_reg) && $stable(state_reg);
    endproperty
    a_cpu_independent: assert property (p_cpu_independent) else $error("processor access disturbed port");

    property p_reset_cmd;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (upd_ir && new_cmd[7:4] == CMD_RST_ASSERT) |=> o_debug_reset ##1 (o_mode.reserved == 1'b0);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("debug reset assert not decoded");

    property p_rsvd_ones;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_cpu_rd_valid |-> (o_cpu_rd_data[RSVD_MSB:RSVD_LSB] == RSVD_READ
                            && o_cpu_rd_data[CMD_MSB:CMD_LSB] == $past(ir_reg[CMD_MSB:CMD_LSB]));
    endproperty
    a_rsvd_ones: assert property (p_rsvd_ones) else $error("read data wrong");

    property p_update_apply;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        upd_ir |=> ir_reg[CMD_MSB:CMD_LSB] == $past(new_cmd);
    endproperty
    a_update_apply: assert property (p_update_apply) else $error("update did not apply command");

endmodule

// >>> dbg_port_pkg.sv
// Package: constants and carrier types of the serial debug port instruction register
package dbg_port_pkg;

    // ****************************************
    // Register layout
    // ****************************************
    localparam int          IR_WIDTH       = 16;
    localparam int          CMD_MSB        = 15;
    localparam int          CMD_LSB        = 8;
    localparam int          RSVD_MSB       = 7;
    localparam int          RSVD_LSB       = 0;
    localparam logic [15:0] IR_RESET_VALUE = 16'hFFFF;
    localparam logic [7:0]  RSVD_READ      = 8'hFF;
    // Low two bits 01 as usual for a scan instruction register capture
    localparam logic [15:0] IR_CAPTURE     = 16'h0001;

    // ****************************************
    // Command codes in the command field
    // ****************************************
    localparam logic [7:0] CMD_EXTEST       = 8'h00;
    localparam logic [7:0] CMD_SAMPLE       = 8'h04;
    localparam logic [3:0] CMD_RST_NEGATE   = 4'h6;
    localparam logic [3:0] CMD_RST_ASSERT   = 4'h7;
    localparam logic [2:0] CMD_INTERRUPT    = 3'h5;
    localparam logic [7:0] CMD_BYPASS       = 8'hFF;

    // ****************************************
    // Test access port controller states
    // ****************************************
    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0,
        TAP_IDLE    = 4'h1,
        TAP_SEL_DR  = 4'h3,
        TAP_CAP_DR  = 4'h2,
        TAP_SH_DR   = 4'h6,
        TAP_EX1_DR  = 4'h7,
        TAP_PA_DR   = 4'h5,
        TAP_EX2_DR  = 4'h4,
        TAP_UPD_DR  = 4'hC,
        TAP_SEL_IR  = 4'hD,
        TAP_CAP_IR  = 4'hF,
        TAP_SH_IR   = 4'hE,
        TAP_EX1_IR  = 4'hA,
        TAP_PA_IR   = 4'hB,
        TAP_EX2_IR  = 4'h9,
        TAP_UPD_IR  = 4'h8
    } tap_state_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_pins_type;

    typedef struct packed {
        logic extest;
        logic sample;
        logic bypass;
        logic reserved;
    } test_mode_type;

endpackage

// >>> tap_ctrl_model.sv
// Behavioural external test controller that drives the test access port pins
`timescale 1ns/1ps

module tap_ctrl_model
    import dbg_port_pkg::*;
(
    // Clock used only to pace the pins
    input  wire logic         i_ref_clk,
    // Test access port pins
    input  wire logic         i_tdo,
    input  wire logic         i_tdo_oe,
    output tap_pins_type      o_tap
);
    // Output enable seen at the last sample point, and shift cycles where it was low
    logic last_oe;
    int   oe_miss = 0;
    // ****************************************
    // Pin timing: one tck period is 16 reference cycles (80 ns)
    // ****************************************
    initial begin
        o_tap = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
    end

    task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
        o_tap.tck = 1'b0;
        o_tap.tms = tms;
        o_tap.tdi = tdi;
        repeat (8) @(negedge i_ref_clk);
        tdo = i_tdo;
        last_oe = i_tdo_oe;
        o_tap.tck = 1'b1;
        repeat (8) @(negedge i_ref_clk);
    endtask

    // Test clock stands still between frames; data line shows no stale value
    task automatic park();
        o_tap.tck = 1'b0;
        o_tap.tdi = ~o_tap.tdi;
        repeat (2) @(negedge i_ref_clk);
    endtask

    task automatic walk(input logic [7:0] tms_seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            tck_cycle(tms_seq[i], o_tap.tdi, d);
        end
    endtask

    // ****************************************
    // Frames
    // ****************************************
    task automatic tlr_idle();
        walk(8'h1F, 6);
        park();
    endtask

    // Low byte comes from the caller, which passes ones there
    task automatic load_ir(input logic [15:0] v, input logic upd, output logic [15:0] cap);
        walk(8'h03, 4);
        for (int i = 0; i < 16; i++) begin
            tck_cycle(i == 15, v[i], cap[i]);
            if (last_oe !== 1'b1) oe_miss++;
        end
        walk(upd ? 8'h01 : 8'h00, 2);
        park();
    endtask

    task automatic finish_update();
        walk(8'h03, 3);
        park();
    endtask

    task automatic trst_pulse();
        o_tap.trst_n = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        o_tap.trst_n = 1'b1;
        repeat (8) @(negedge i_ref_clk);
    endtask
endmodule

// >>> tb.sv
// Self-checking bench for the serial debug port instruction register
`timescale 1ns/1ps

module tb;
    import dbg_port_pkg::*;
    logic          clk;
    logic          rst_n;
    tap_pins_type  tap;
    logic          tdo, tdo_oe, rd_en, rd_valid, dbg_rst, dbg_irq;
    logic [15:0]   rd_data;
    test_mode_type mode;
    int            fail_count = 0;
    int            samples_checked = 0;
    int            irq_seen = 0;
    int            exp_irq = 0;
    int            chain_pulses = 0;
    logic          chain_cap, chain_sh, chain_upd;
    logic          exp_rst = 1'b0;
    logic [15:0]   exp_ir = 16'hFFFF;
    logic [31:0]   seed = 32'h000044BC;

    dbg_port_ir dbg_port_ir_i (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_tap(tap), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_chain_tdo(1'b0), .i_cpu_rd_en(rd_en), .o_cpu_rd_data(rd_data), .o_cpu_rd_valid(rd_valid),
        .o_mode(mode), .o_debug_reset(dbg_rst), .o_debug_irq(dbg_irq),
        .o_chain_capture(chain_cap), .o_chain_shift(chain_sh), .o_chain_update(chain_upd)
    );

    tap_ctrl_model tap_ctrl_model_i (.i_ref_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tap(tap));

    // ****************************************
    // Reference model and helpers
    // ****************************************
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [3:0] exp_mode(logic [7:0] c);
        if (c == 8'h00) return 4'h8;
        if (c == 8'h04) return 4'h4;
        if (c == 8'hFF) return 4'h2;
        if (c[7:4] == 4'h6 || c[7:4] == 4'h7 || c[7:5] == 3'h5) return 4'h0;
        return 4'h1;
    endfunction

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_and_compare();
        int n;
        @(negedge clk);
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        check("rd_valid", 16'h0001, {15'h0, rd_valid});
        check("rd_data", exp_ir, rd_data);
        check("mode", {12'h0, exp_mode(exp_ir[15:8])}, {12'h0, mode});
        check("debug_reset", {15'h0, exp_rst}, {15'h0, dbg_rst});
        check("irq_count", exp_irq[15:0], irq_seen[15:0]);
        check("tdo_oe_idle", 16'h0000, {15'h0, tdo_oe});
        check("chain_pulses", 16'h0000, chain_pulses[15:0]);
    endtask

    task automatic apply(logic [7:0] code);
        logic [15:0] cap;
        tap_ctrl_model_i.load_ir({code, 8'hFF}, 1'b1, cap);
        check("capture", IR_CAPTURE, cap);
        check("tdo_oe_shift", 16'h0000, tap_ctrl_model_i.oe_miss[15:0]);
        exp_ir = {code, 8'hFF};
        if (code[7:4] == 4'h7) exp_rst = 1'b1;
        if (code[7:4] == 4'h6) exp_rst = 1'b0;
        if (code[7:5] == 3'h5) exp_irq++;
        read_and_compare();
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, pulse counter, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (dbg_irq === 1'b1) irq_seen++;
        // No data register scan is run, so the boundary chain must stay quiet
        if ((chain_cap | chain_sh | chain_upd) === 1'b1) chain_pulses++;
    end

    // Run needs about 29 us; a wide margin still stays under 100k cycles
    initial begin
        #300us;
        fail_count++;
        report_and_stop();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [7:0]  code_list [7];
        logic [7:0]  code;
        logic [31:0] r;
        logic [15:0] cap;
        rst_n = 1'b0;
        rd_en = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        read_and_compare();
        tap_ctrl_model_i.tlr_idle();
        code_list = '{8'h00, 8'h04, 8'h70, 8'hA0, 8'hA0, 8'h60, 8'hFF};
        for (int k = 0; k < 11; k++) begin
            r = xorshift();
            // Only defined codes are loaded; random bits go where the decode ignores them
            code = code_list[(k < 7) ? k : (r[18:16] % 7)];
            if (code[7:5] == 3'h3) code[3:0] = r[3:0];
            if (code[7:5] == 3'h5) code[4:0] = r[4:0];
            apply(code);
        end
        // New command stays pending while paused before the update state
        tap_ctrl_model_i.load_ir(16'h00FF, 1'b0, cap);
        read_and_compare();
        tap_ctrl_model_i.finish_update();
        exp_ir = 16'h00FF;
        read_and_compare();
        apply(8'h7A);
        tap_ctrl_model_i.tlr_idle();
        exp_ir = 16'hFFFF;
        exp_rst = 1'b0;
        read_and_compare();
        apply(8'h04);
        tap_ctrl_model_i.trst_pulse();
        exp_ir = 16'hFFFF;
        read_and_compare();
        tap_ctrl_model_i.tlr_idle();
        apply(8'h00);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        exp_ir = 16'hFFFF;
        exp_rst = 1'b0;
        read_and_compare();
        report_and_stop();
    end
endmodule
